// File: uart_flow_threshold_regs_tb.sv
`timescale 1ns/1ps
module uart_flow_threshold_regs_tb;
	import uftr_pkg::*;
	logic        clk_sys   = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        chanB     = 1'b0;
	logic [1:0]  rxRdyIn   = 2'b10;
	logic [1:0]  txRdyIn   = 2'b01;
	logic [1:0]  fifoRxSel = 2'h0;
	logic [1:0]  fifoTxSel = 2'h3;
	logic [6:0]  rxFill    = 7'h00;
	uftr_bus_t   bus;
	uftr_trig_t  trig;
	logic [7:0]  rdata;
	logic [7:0]  intEnOut;
	logic [7:0]  fifoCtrlOut;
	logic [7:0]  enhFeatOut;
	logic [7:0]  rdV;
	logic [15:0] divisor;
	logic        prescDiv4;
	logic        rtsOut;
	logic [31:0] flowChars;
	int          errors    = 0;
	int          cmp_count = 0;

	always #5 clk_sys = ~clk_sys;

	uftr_host host (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));

	uftr_regs #(.FILL_W(7)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
		.chanB(chanB), .rxRdyIn(rxRdyIn), .txRdyIn(txRdyIn), .fifoRxSel(fifoRxSel),
		.fifoTxSel(fifoTxSel), .rxFill(rxFill), .rdata(rdata), .divisor(divisor),
		.prescDiv4(prescDiv4), .intEnOut(intEnOut), .fifoCtrlOut(fifoCtrlOut), .trig(trig),
		.rtsOut(rtsOut), .enhFeatOut(enhFeatOut), .flowChars(flowChars));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Fill changes are given a few edges since the pin level is registered
	task automatic set_fill(input logic [6:0] v);
		@(posedge clk_sys);
		#1 rxFill = v;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_rts(input logic exp);
		int n;
		n = 0;
		while (rtsOut !== exp && n < 8) begin
			@(posedge clk_sys);
			#1 n++;
		end
		check(rtsOut, exp);
		if (rtsOut !== exp) begin
			results();
		end
	endtask

	task automatic t_divisor();
		check(divisor, 16'h0000);
		host.wr(ADDR_LINE_CTRL, 8'h80);
		host.wr(ADDR_DIV_LOW, 8'h5a);
		host.wr(ADDR_DIV_HIGH, 8'hc3);
		host.rd(ADDR_DIV_LOW, rdV);
		check(rdV, 8'h5a);
		check(divisor, 16'hc35a);
		host.wr(ADDR_LINE_CTRL, 8'h00);
	endtask

	// Enhanced enable still clear after reset
	task automatic t_locked();
		host.wr(ADDR_MODEM_CTRL, 8'he0);
		host.wr(ADDR_TRIG_LVL, 8'h55);
		host.wr(ADDR_DIV_HIGH, 8'hff);
		host.wr(ADDR_ENH_FEAT, 8'hff);
		check(prescDiv4, 1'b0);
		check(intEnOut, 8'h0f);
		check(fifoCtrlOut, 8'hcf);
		check(trig, {RX_LVL_0, TX_LVL_3, 2'b00});
	endtask

	task automatic t_chars();
		host.wr(ADDR_LINE_CTRL, LINE_KEY_ENH);
		host.wr(ADDR_STOP_1, 8'h11);
		host.wr(ADDR_RESUME_1, 8'h22);
		host.wr(ADDR_STOP_2, 8'h33);
		host.wr(ADDR_RESUME_2, 8'h44);
		host.wr(ADDR_ENH_FEAT, 8'h1a);
		check(flowChars, 32'h33114422);
		check(enhFeatOut, 8'h1a);
		host.wr(ADDR_LINE_CTRL, 8'h00);
		host.rd(ADDR_ENH_FEAT, rdV);
		check(rdV, 8'h00);
	endtask

	task automatic t_thresh();
		host.unlock(8'h10, 8'h40);
		// Halt above resume, loaded before flow control
		host.wr(ADDR_FLOW_THR, 8'h3a);
		// Level 20 written as 5, FIFO-control left alone
		host.wr(ADDR_TRIG_LVL, 8'h50);
		host.rd(ADDR_FLOW_THR, rdV);
		check(rdV, 8'h3a);
		host.rd(ADDR_TRIG_LVL, rdV);
		check(rdV, 8'h50);
		check(trig, {6'd20, TX_LVL_3, 2'b10});
		host.wr(ADDR_TRIG_LVL, 8'hf1);
		check(trig, {6'd60, 6'd4, 2'b11});
		host.unlock(8'h50, 8'hc0);
		check(prescDiv4, 1'b1);
		set_fill(7'd39);
		check(rtsOut, 1'b0);
		set_fill(7'd40);
		wait_rts(1'b1);
		set_fill(7'd13);
		check(rtsOut, 1'b1);
		set_fill(7'd12);
		wait_rts(1'b0);
	endtask

	task automatic t_ready();
		// Ready window opened through modem control
		host.wr(ADDR_MODEM_CTRL, 8'h44);
		host.rd(ADDR_FIFO_RDY, rdV);
		check(rdV, 8'h21);
		rxRdyIn = 2'b01;
		txRdyIn = 2'b10;
		host.rd(ADDR_FIFO_RDY, rdV);
		check(rdV, 8'h12);
		host.wr(ADDR_MODEM_CTRL, 8'h54);
		host.rd(ADDR_FIFO_RDY, rdV);
		check(rdV, 8'hf1);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		t_divisor();
		t_locked();
		t_chars();
		t_thresh();
		t_ready();
		results();
	end
endmodule

// File: uftr_host.sv
`timescale 1ns/1ps
module uftr_host
	import uftr_pkg::*;
(
	input  wire logic       clk_sys, // Bus clock
	input  wire logic [7:0] rdata,   // Read data from device
	output uftr_bus_t       bus      // Host bus, selects active low
);
	initial begin
		bus = '{1'b1, 1'b1, 3'h0, 1'b0, 1'b0, 8'h00};
	end

	// Released lines carry the inverse so a stale value never looks valid
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 bus = '{1'b0, 1'b1, a, 1'b1, 1'b0, d};
		@(posedge clk_sys);
		#1 bus = '{1'b1, 1'b1, ~a, 1'b0, 1'b0, ~d};
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1 bus = '{1'b0, 1'b1, a, 1'b0, 1'b1, ~bus.wdata};
		@(posedge clk_sys);
		d = rdata;
		#1 bus = '{1'b1, 1'b1, ~a, 1'b0, 1'b0, ~bus.wdata};
	endtask

	task automatic unlock(input logic [7:0] enhanced_feature_ctrl, input logic [7:0] modem_ctrl);
		wr(ADDR_LINE_CTRL, LINE_KEY_ENH);
		wr(ADDR_ENH_FEAT, enhanced_feature_ctrl);
		wr(ADDR_LINE_CTRL, 8'h00);
		wr(ADDR_MODEM_CTRL, modem_ctrl);
	endtask
endmodule

// File: uftr_pkg.sv
package uftr_pkg;
	// Register addresses
	localparam logic [2:0] ADDR_DIV_LOW    = 3'h0;
	localparam logic [2:0] ADDR_DIV_HIGH   = 3'h1;
	localparam logic [2:0] ADDR_ENH_FEAT   = 3'h2;
	localparam logic [2:0] ADDR_LINE_CTRL  = 3'h3;
	localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
	localparam logic [2:0] ADDR_RESUME_1   = 3'h4;
	localparam logic [2:0] ADDR_RESUME_2   = 3'h5;
	localparam logic [2:0] ADDR_STOP_1     = 3'h6;
	localparam logic [2:0] ADDR_FLOW_THR   = 3'h6;
	localparam logic [2:0] ADDR_STOP_2     = 3'h7;
	localparam logic [2:0] ADDR_TRIG_LVL   = 3'h7;
	localparam logic [2:0] ADDR_FIFO_RDY   = 3'h7;
	// Line-control keys
	localparam logic [7:0] LINE_KEY_ENH     = 8'hbf;
	localparam int         LINE_DIV_BIT     = 7;
	// Field positions
	localparam int         ENH_EN_BIT       = 4;
	localparam int         ENH_RTS_BIT      = 6;
	localparam int         MODEM_PRESC_BIT  = 7;
	localparam int         MODEM_THR_BIT    = 6;
	localparam int         MODEM_LOOP_BIT   = 4;
	localparam int         MODEM_RDY_BIT    = 2;
	localparam logic [7:0] MODEM_PROT_MASK  = 8'he0;
	localparam logic [7:0] INT_EN_PROT_MASK = 8'hf0;
	localparam logic [7:0] FIFO_PROT_MASK   = 8'h30;
	localparam int         LVL_SHIFT        = 2;
	// FIFO-control trigger choices in characters; the table is a free choice
	localparam logic [5:0] RX_LVL_0         = 6'h08;
	localparam logic [5:0] RX_LVL_1         = 6'h10;
	localparam logic [5:0] RX_LVL_2         = 6'h38;
	localparam logic [5:0] RX_LVL_3         = 6'h3c;
	localparam logic [5:0] TX_LVL_0         = 6'h08;
	localparam logic [5:0] TX_LVL_1         = 6'h10;
	localparam logic [5:0] TX_LVL_2         = 6'h20;
	localparam logic [5:0] TX_LVL_3         = 6'h38;
	// Reset values; zero chosen
	localparam logic [7:0] RST_REG          = 8'h00;
	localparam logic [7:0] RST_LINE         = 8'h00;

	typedef struct packed {
		logic       chip_select_chan_a;
		logic       chip_select_chan_b;
		logic [2:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} uftr_bus_t;

	typedef struct packed {
		logic [5:0] rxTrig;
		logic [5:0] txTrig;
		logic       rxFromLvl;
		logic       txFromLvl;
	} uftr_trig_t;
endpackage

// File: uftr_regs.sv
`timescale 1ns/1ps
module uftr_regs
	import uftr_pkg::*;
#(
	parameter int FILL_W = 7
) (
	input  wire logic              clk_sys,     // 100 MHz clock
	input  wire logic              sys_rst,     // Synchronous reset, active high
	input  wire uftr_bus_t         bus,         // Host access, selects active low
	input  wire logic              chanB,       // This instance serves channel B
	input  wire logic [1:0]        rxRdyIn,     // Receive ready of channels B,A
	input  wire logic [1:0]        txRdyIn,     // Transmit ready of channels B,A
	input  wire logic [1:0]        fifoRxSel,   // FIFO-control receive trigger choice
	input  wire logic [1:0]        fifoTxSel,   // FIFO-control transmit trigger choice
	input  wire logic [FILL_W-1:0] rxFill,      // Receive FIFO fill in bytes
	output logic [7:0]             rdata,       // Read data
	output logic [15:0]            divisor,     // Baud divisor
	output logic                   prescDiv4,   // Prescaler divide-by-4
	output logic [7:0]             intEnOut,    // Interrupt enable
	output logic [7:0]             fifoCtrlOut, // FIFO control
	output uftr_trig_t             trig,        // Effective trigger levels
	output logic                   rtsOut,      // Request-to-send pin level
	output logic [7:0]             enhFeatOut,  // Enhanced feature bits
	output logic [31:0]            flowChars    // Stop2,stop1,resume2,resume1
);
	typedef enum logic [1:0] {UFTR_BANK_BASE = 2'b00, UFTR_BANK_DIV = 2'b01,
		UFTR_BANK_ENH = 2'b11} uftr_bank_t;

	// Host-visible registers
	logic [7:0]        lineCtrl_q;
	logic [7:0]        lineCtrl_d;
	logic [7:0]        modemCtrl_q;
	logic [7:0]        modemCtrl_d;
	logic [7:0]        enhFeat_q;
	logic [7:0]        enhFeat_d;
	logic [7:0]        intEn_q;
	logic [7:0]        intEn_d;
	logic [7:0]        fifoCtrl_q;
	logic [7:0]        fifoCtrl_d;
	logic [7:0]        divLow_q;
	logic [7:0]        divLow_d;
	logic [7:0]        divHigh_q;
	logic [7:0]        divHigh_d;
	logic [7:0]        flowThr_q;
	logic [7:0]        flowThr_d;
	logic [7:0]        trigLvl_q;
	logic [7:0]        trigLvl_d;
	logic [7:0]        resume1_q;
	logic [7:0]        resume1_d;
	logic [7:0]        resume2_q;
	logic [7:0]        resume2_d;
	logic [7:0]        stop1_q;
	logic [7:0]        stop1_d;
	logic [7:0]        stop2_q;
	logic [7:0]        stop2_d;
	// Request-to-send state
	logic              rts_q;
	logic              rts_d;
	// Decodes
	logic              sel;
	logic              enh;
	logic              thrOpen;
	logic              rdyOpen;
	logic              rxOwn;
	logic              txOwn;
	logic [FILL_W-1:0] haltLvl;
	logic [FILL_W-1:0] resumeLvl;
	uftr_bank_t        bank;

	// Protected bits keep their old value unless the enable is set
	function automatic logic [7:0] guarded(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] mask, input logic en);
		guarded = en ? nw : ((nw & ~mask) | (old & mask));
	endfunction

	function automatic logic [5:0] fifoCtrlLevel(input logic [1:0] s, input logic rx);
		case (s)
			2'b00: begin
				fifoCtrlLevel = rx ? RX_LVL_0 : TX_LVL_0;
			end
			2'b01: begin
				fifoCtrlLevel = rx ? RX_LVL_1 : TX_LVL_1;
			end
			2'b10: begin
				fifoCtrlLevel = rx ? RX_LVL_2 : TX_LVL_2;
			end
			default: begin
				fifoCtrlLevel = rx ? RX_LVL_3 : TX_LVL_3;
			end
		endcase
	endfunction

	assign sel     = chanB ? ~bus.chip_select_chan_b : ~bus.chip_select_chan_a;
	assign enh     = enhFeat_q[ENH_EN_BIT];
	assign thrOpen = enh && modemCtrl_q[MODEM_THR_BIT];
	assign rdyOpen = (~bus.chip_select_chan_a | ~bus.chip_select_chan_b) && modemCtrl_q[MODEM_RDY_BIT]
		&& !modemCtrl_q[MODEM_LOOP_BIT];

	always_comb begin
		if (lineCtrl_q == LINE_KEY_ENH) begin
			bank = UFTR_BANK_ENH;
		end else if (lineCtrl_q[LINE_DIV_BIT]) begin
			bank = UFTR_BANK_DIV;
		end else begin
			bank = UFTR_BANK_BASE;
		end
	end

	always_comb begin
		lineCtrl_d  = lineCtrl_q;
		modemCtrl_d = modemCtrl_q;
		enhFeat_d   = enhFeat_q;
		intEn_d     = intEn_q;
		fifoCtrl_d  = fifoCtrl_q;
		divLow_d    = divLow_q;
		divHigh_d   = divHigh_q;
		flowThr_d   = flowThr_q;
		trigLvl_d   = trigLvl_q;
		resume1_d   = resume1_q;
		resume2_d   = resume2_q;
		stop1_d     = stop1_q;
		stop2_d     = stop2_q;
		if (sel && bus.wr) begin
			case (bus.addr)
				ADDR_DIV_LOW: begin
					// divisor behind line control bit 7
					if (bank != UFTR_BANK_BASE)
						divLow_d = bus.wdata;
				end
				ADDR_DIV_HIGH: begin
					if (bank != UFTR_BANK_BASE)
						divHigh_d = bus.wdata;
					else
						intEn_d = guarded(intEn_q, bus.wdata, INT_EN_PROT_MASK, enh);
				end
				ADDR_ENH_FEAT: begin
					if (bank == UFTR_BANK_ENH)
						enhFeat_d = bus.wdata;
					else
						fifoCtrl_d = guarded(fifoCtrl_q, bus.wdata, FIFO_PROT_MASK, enh);
				end
				ADDR_LINE_CTRL: begin
					lineCtrl_d = bus.wdata;
				end
				ADDR_MODEM_CTRL: begin
					if (bank == UFTR_BANK_ENH)
						resume1_d = bus.wdata;
					else
						modemCtrl_d = guarded(modemCtrl_q, bus.wdata, MODEM_PROT_MASK, enh);
				end
				ADDR_RESUME_2: begin
					if (bank == UFTR_BANK_ENH)
						resume2_d = bus.wdata;
				end
				ADDR_STOP_1: begin
					if (bank == UFTR_BANK_ENH)
						stop1_d = bus.wdata;
					else if (thrOpen)
						flowThr_d = bus.wdata;
				end
				default: begin
					if (bank == UFTR_BANK_ENH)
						stop2_d = bus.wdata;
					else if (thrOpen)
						trigLvl_d = bus.wdata;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lineCtrl_q  <= RST_LINE;
			modemCtrl_q <= RST_REG;
			enhFeat_q   <= RST_REG;
			intEn_q     <= RST_REG;
			fifoCtrl_q  <= RST_REG;
			divLow_q    <= RST_REG;
			divHigh_q   <= RST_REG;
			flowThr_q   <= RST_REG;
			trigLvl_q   <= RST_REG;
			resume1_q   <= RST_REG;
			resume2_q   <= RST_REG;
			stop1_q     <= RST_REG;
			stop2_q     <= RST_REG;
		end else begin
			lineCtrl_q  <= lineCtrl_d;
			modemCtrl_q <= modemCtrl_d;
			enhFeat_q   <= enhFeat_d;
			intEn_q     <= intEn_d;
			fifoCtrl_q  <= fifoCtrl_d;
			divLow_q    <= divLow_d;
			divHigh_q   <= divHigh_d;
			flowThr_q   <= flowThr_d;
			trigLvl_q   <= trigLvl_d;
			resume1_q   <= resume1_d;
			resume2_q   <= resume2_d;
			stop1_q     <= stop1_d;
			stop2_q     <= stop2_d;
		end
	end

	// Read mux; outside the enhanced bank, ready status wins over trigger level at address 7 since it is a plain status view
	always_comb begin
		rdata = 8'h00;
		if (sel && bus.rd) begin
			case (bus.addr)
				ADDR_DIV_LOW: begin
					rdata = (bank != UFTR_BANK_BASE) ? divLow_q : 8'h00;
				end
				ADDR_DIV_HIGH: begin
					rdata = (bank != UFTR_BANK_BASE) ? divHigh_q : intEn_q;
				end
				ADDR_ENH_FEAT: begin
					// FIFO control is write-only here
					rdata = (bank == UFTR_BANK_ENH) ? enhFeat_q : 8'h00;
				end
				ADDR_LINE_CTRL: begin
					rdata = lineCtrl_q;
				end
				ADDR_MODEM_CTRL: begin
					rdata = (bank == UFTR_BANK_ENH) ? resume1_q : modemCtrl_q;
				end
				ADDR_RESUME_2: begin
					rdata = (bank == UFTR_BANK_ENH) ? resume2_q : 8'h00;
				end
				ADDR_STOP_1: begin
					if (bank == UFTR_BANK_ENH)
						rdata = stop1_q;
					else if (thrOpen)
						rdata = flowThr_q;
				end
				default: begin
					if (bank == UFTR_BANK_ENH)
						rdata = stop2_q;
					else if (rdyOpen)
						rdata = {2'b00, rxRdyIn, 2'b00, txRdyIn};
					else if (thrOpen)
						rdata = trigLvl_q;
				end
			endcase
		end
	end

	assign rxOwn = (trigLvl_q[7:4] != 4'h0);
	assign txOwn = (trigLvl_q[3:0] != 4'h0);
	always_comb begin
		trig.rxFromLvl = rxOwn;
		trig.txFromLvl = txOwn;
		trig.rxTrig    = rxOwn ? {trigLvl_q[7:4], 2'b00} : fifoCtrlLevel(fifoRxSel, 1'b1);
		trig.txTrig    = txOwn ? {trigLvl_q[3:0], 2'b00} : fifoCtrlLevel(fifoTxSel, 1'b0);
	end

	// auto request-to-send hysteresis
	// Halt is tested first, so a misordered pair (halt not above resume) still halts
	assign haltLvl   = FILL_W'({flowThr_q[3:0], 2'b00});
	assign resumeLvl = FILL_W'({flowThr_q[7:4], 2'b00});
	always_comb begin
		rts_d = rts_q;
		if (!enhFeat_q[ENH_RTS_BIT]) begin
			rts_d = 1'b0;
		end else if (rxFill >= haltLvl) begin
			rts_d = 1'b1;
		end else if (rxFill <= resumeLvl) begin
			rts_d = 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rts_q <= 1'b0;
		end else begin
			rts_q <= rts_d;
		end
	end

	assign divisor     = {divHigh_q, divLow_q};
	assign prescDiv4   = modemCtrl_q[MODEM_PRESC_BIT];
	assign intEnOut    = intEn_q;
	assign fifoCtrlOut = fifoCtrl_q;
	assign rtsOut      = rts_q;
	assign enhFeatOut  = enhFeat_q;
	assign flowChars   = {stop2_q, stop1_q, resume2_q, resume1_q};

	a_thr_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!thrOpen |=> $stable(flowThr_q)) else $error("flow threshold changed while locked");
	a_lvl_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!thrOpen |=> $stable(trigLvl_q)) else $error("trigger level changed while locked");
	a_modem_guard: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!enh |=> modemCtrl_q[7:5] == $past(modemCtrl_q[7:5]))
		else $error("guarded modem bits moved");
	a_int_guard: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!enh |=> intEn_q[7:4] == $past(intEn_q[7:4]))
		else $error("guarded interrupt enable bits moved");
	a_fifo_guard: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!enh |=> fifoCtrl_q[5:4] == $past(fifoCtrl_q[5:4]))
		else $error("guarded fifo control bits moved");
	a_presc_guard: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!enh |=> prescDiv4 == $past(prescDiv4)) else $error("prescaler moved while locked");
	a_rts_halt: assert property (@(posedge clk_sys) disable iff (sys_rst)
		enhFeat_q[ENH_RTS_BIT] && rxFill >= haltLvl |=> rtsOut) else $error("rts not raised");
	a_rts_resume: assert property (@(posedge clk_sys) disable iff (sys_rst)
		enhFeat_q[ENH_RTS_BIT] && rxFill < haltLvl && rxFill <= resumeLvl |=> !rtsOut)
		else $error("rts not dropped at resume level");
	// request-to-send idle while auto mode off
	a_rts_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!enhFeat_q[ENH_RTS_BIT] |=> !rtsOut) else $error("rts high with auto mode off");
	a_rx_override: assert property (@(posedge clk_sys) disable iff (sys_rst)
		trigLvl_q[7:4] != 4'h0 |-> trig.rxTrig == {trigLvl_q[7:4], 2'b00} && trig.rxFromLvl)
		else $error("receive trigger override wrong");
	a_tx_override: assert property (@(posedge clk_sys) disable iff (sys_rst)
		trigLvl_q[3:0] != 4'h0 |-> trig.txTrig[5:2] == trigLvl_q[3:0] && trig.txTrig[1:0] == 2'b00)
		else $error("transmit trigger override wrong");
	// zero field falls back to FIFO-control choice
	a_rx_fallback: assert property (@(posedge clk_sys) disable iff (sys_rst)
		trigLvl_q[7:4] == 4'h0 && fifoRxSel == 2'b00 |-> trig.rxTrig == RX_LVL_0)
		else $error("receive trigger fallback wrong");
	a_rdy_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel && bus.rd && bus.addr == ADDR_FIFO_RDY && bank != UFTR_BANK_ENH && rdyOpen
		|-> rdata[7:6] == 2'b00 && rdata[3:2] == 2'b00 && rdata[5:4] == rxRdyIn)
		else $error("ready register layout wrong");
	// address 7 hidden when nothing opens it
	a_rdy_hidden: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel && bus.rd && bus.addr == ADDR_FIFO_RDY && bank != UFTR_BANK_ENH && !rdyOpen
		&& !thrOpen |-> rdata == 8'h00)
		else $error("address 7 read while closed");
	a_thr_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel && bus.rd && bus.addr == ADDR_FLOW_THR && bank == UFTR_BANK_BASE && thrOpen
		|-> rdata == flowThr_q)
		else $error("flow threshold not readable");
	a_enh_key: assert property (@(posedge clk_sys) disable iff (sys_rst)
		lineCtrl_q != LINE_KEY_ENH |=> $stable(enhFeat_q))
		else $error("enhanced feature without key");
	a_chars_key: assert property (@(posedge clk_sys) disable iff (sys_rst)
		lineCtrl_q != LINE_KEY_ENH |=> $stable(flowChars))
		else $error("flow characters written without key");
	a_div_key: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!lineCtrl_q[LINE_DIV_BIT] |=> $stable(divLow_q)) else $error("divisor written unlocked");
	a_divh_key: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!lineCtrl_q[LINE_DIV_BIT] |=> $stable(divHigh_q))
		else $error("divisor high written unlocked");
endmodule
